/* File: hw/acm_defines.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: ref_clk at 100 MHz; register index times four is the byte address
// Notes:   timeouts are least times, rounded up to whole cycles
`ifndef ACM_DEFINES_SVH
`define ACM_DEFINES_SVH

`define ACM_CLK_MHZ    100
// register indices
`define ACM_IDX_DET    8'h5E
`define ACM_IDX_ERR    8'h5F
`define ACM_IDX_CTL    8'h25
// detector status fields
`define ACM_B_HALT     6
`define ACM_B_PLL      5
`define ACM_B_SMISS    4
`define ACM_B_AUTO     3
`define ACM_B_MINV     2
`define ACM_B_BINV     1
`define ACM_B_SINV     0
// error status fields
`define ACM_B_LATCHED_HALT_FLAG     4
`define ACM_B_CLOCK_MISSING_FLAG     2
`define ACM_B_RESYNC_IN_PROGRESS     1
`define ACM_B_CLOCK_ERROR_FLAG     0
// control fields
`define ACM_B_IGN      0
`define ACM_B_PLLEN    1
// writable masks and reset values
`define ACM_DET_RSV    8'h80
`define ACM_ERR_RSV    8'hE8
`define ACM_RSV_RST    8'h00
`define ACM_CTL_RST    8'h02
// bit clock ratio window and short low phase
`define ACM_BCK_MIN    10'h020
`define ACM_BCK_MAX    10'h100
`define ACM_LOW_SHORT  10'h005
// times in ns and derived cycle counts
`define ACM_HALT_NS    1000
`define ACM_MISS_NS    20000
`define ACM_FRAME_NS   40000
`define ACM_RESYNC_NS  2000
`define ACM_CYC(ns)    12'((((ns) * `ACM_CLK_MHZ) + 999) / 1000)
`define ACM_HALT_CYC   `ACM_CYC(`ACM_HALT_NS)
`define ACM_MISS_CYC   `ACM_CYC(`ACM_MISS_NS)
`define ACM_FRAME_CYC  `ACM_CYC(`ACM_FRAME_NS)
`define ACM_RESYNC_CYC `ACM_CYC(`ACM_RESYNC_NS)

`endif

/* File: hw/acm_link.sv */
// Purpose: frame measurement on the bit clock
// Assumes: frame clock changes away from the rising bit clock edge
// Notes:   bit clock stops when absent; the ref side times out on its own
`include "acm_defines.svh"
`timescale 1ns/10ps
module acm_link (
	input  wire logic       link_clk,
	input  wire logic       srst,
	input  wire logic       lrclk,
	output logic      [9:0] bits,
	output logic            short_low,
	output logic            tgl
);
	import acm_pkg::*;

	acm_link_st_t st_r;
	acm_link_st_t st_nxt;

	always_comb begin
		st_nxt      = st_r;
		st_nxt.rs1  = srst;
		st_nxt.rs2  = st_r.rs1;
		st_nxt.lr_d = lrclk;
		if (st_r.rs2) begin
			st_nxt.bit_cnt   = '0;
			st_nxt.low_cnt   = '0;
			st_nxt.bits      = '0;
			st_nxt.short_low = 1'b0;
			st_nxt.tgl       = 1'b0;
		end else begin
			if (lrclk && !st_r.lr_d) begin
				// frame start: publish the word and flip the toggle on the same edge
				st_nxt.bits      = st_r.bit_cnt;
				st_nxt.short_low = (st_r.low_cnt <= `ACM_LOW_SHORT); // RULE6
				st_nxt.bit_cnt   = 10'h001;
				st_nxt.tgl       = ~st_r.tgl;
			end else if (st_r.bit_cnt != 10'h3FF) begin
				st_nxt.bit_cnt = st_r.bit_cnt + 10'h001;
			end
			if (lrclk) begin
				st_nxt.low_cnt = '0;
			end else if (st_r.low_cnt != 10'h3FF) begin
				st_nxt.low_cnt = st_r.low_cnt + 10'h001;
			end
		end
	end

	always_ff @(posedge link_clk) begin
		st_r <= st_nxt;
	end

	assign bits      = st_r.bits;
	assign short_low = st_r.short_low;
	assign tgl       = st_r.tgl;
endmodule

/* File: hw/acm_pkg.sv */
// Purpose: types for the audio clock monitor
// Assumes: nothing
// Notes:   each module keeps all its state in one struct
package acm_pkg;

	typedef logic [31:0] acm_word_t;
	typedef logic [1:0]  acm_trans_t;

	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
		logic [3:0] s3;
	} acm_sync_st_t;

	typedef struct packed {
		logic       rs1;
		logic       rs2;
		logic       lr_d;
		logic [9:0] bit_cnt;
		logic [9:0] low_cnt;
		logic [9:0] bits;
		logic       short_low;
		logic       tgl;
	} acm_link_st_t;

	typedef struct packed {
		logic        mclk_q;
		logic        lr_q;
		logic        sck_q;
		logic        pll_q;
		logic        tg_s1;
		logic        tg_s2;
		logic        tg_d;
		logic [11:0] halt_cnt;
		logic [11:0] miss_cnt;
		logic [11:0] frame_cnt;
		logic [11:0] mclk_cnt;
		logic [11:0] ratio;
		logic [11:0] rsy_cnt;
		logic [9:0]  bits_cur;
		logic [9:0]  bits_prev;
		logic        low_short;
		logic        frame_ok;
		logic        halted;
		logic        miss;
		logic        halt_d;
		logic        err_d;
		logic        latched_halt_flag;
		logic        clock_error_flag;
		logic [7:0]  det_rsv;
		logic [7:0]  err_rsv;
		logic [7:0]  ctl;
		logic [7:0]  rdata;
		logic        dp_wr;
		logic [7:0]  dp_idx;
		logic        hready;
	} acm_st_t;

	// master clock to frame ratios that the detector accepts
	function automatic logic acm_ratio_ok(input logic [11:0] r);
		case (r)
			12'h020, 12'h030, 12'h040, 12'h080, 12'h0C0, 12'h100, 12'h180,
			12'h200, 12'h300, 12'h400, 12'h480, 12'h600, 12'h800,
			12'hC00: acm_ratio_ok = 1'b1;
			default: acm_ratio_ok = 1'b0;
		endcase
	endfunction

endpackage

/* File: hw/acm_sync.sv */
// Purpose: three-stage synchroniser for the pin inputs
// Assumes: inputs are asynchronous to clk
// Notes:   the caller takes a change once s2 and s3 agree
`timescale 1ns/10ps
module acm_sync (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic [3:0] din,
	output logic      [3:0] s2,
	output logic      [3:0] s3
);
	import acm_pkg::*;

	acm_sync_st_t st_r;
	acm_sync_st_t st_nxt;

	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = din;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign s2 = st_r.s2;
	assign s3 = st_r.s3;
endmodule

/* File: hw/acm_top.sv */
// Purpose: audio clock detector status with AHB-Lite registers
// Assumes: single word transfers; master clock below a quarter of ref_clk
// Notes:   frame words cross from the bit clock domain by toggle
// Overview of operation
// RULE1: halt bit 6 is one while master clock missing, zero when present.
// RULE2: pll unlocked bit 5 is one when not locked or disabled.
// RULE3: bit 4 set only while frame and bit clocks both stay low.
// RULE4: bit 3 flags rate and master ratio unusable for auto setup.
// RULE5: bit 2 flags master clock whose frame ratio is not detectable.
// RULE6: bit 2 also set when frame low phase is five bit clocks or less.
// RULE7: bit 1 set unless bit clocks per frame stable within 32 to 256.
// RULE8: bit 0 flags an undetectable sample rate.
// RULE9: ignore setting forces the sample rate flag low.
// RULE10: latched halt bit 4 of second register sets on halt, clears on read.
// RULE11: clock error bit 0 of second register sets on error, clears on read.
// RULE12: resync bit 1 of second register high while resync runs.
// RULE13: clock missing bit 2 of second register mirrors both clocks low.
// RULE14: status bits ignore writes; reserved bits store writes, zero at reset.
`include "acm_defines.svh"
`timescale 1ns/10ps
module acm_top (
	input  wire logic               ref_clk,
	input  wire logic               srst,
	input  wire logic               hsel,
	input  wire acm_pkg::acm_word_t haddr,
	input  wire acm_pkg::acm_trans_t htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire acm_pkg::acm_word_t hwdata,
	input  wire logic               hready,
	output logic                    hreadyout,
	output logic                    hresp,
	output acm_pkg::acm_word_t      hrdata,
	input  wire logic               mclk_pin,
	input  wire logic               lrclk_pin,
	input  wire logic               sclk_link,
	input  wire logic               pll_lock
);
	import acm_pkg::*;

	acm_st_t    st_r;
	acm_st_t    st_nxt;
	logic [3:0] pin_s2;
	logic [3:0] pin_s3;
	logic [9:0] lk_bits;
	logic       lk_short;
	logic       lk_tgl;
	logic       ap_valid;
	logic       ap_rd;
	logic [7:0] ap_idx;
	logic       frame_evt;
	logic       ratio_ok;
	logic       sr_inv;
	logic       minv;
	logic       binv;
	logic       auto_err;
	logic       pll_unl;
	logic       any_err;
	logic       rsy;
	logic       rd_err;
	logic [7:0] det_live;
	logic [7:0] err_live;

	acm_sync u_sync (
		.clk  (ref_clk),
		.srst (srst),
		.din  ({pll_lock, sclk_link, lrclk_pin, mclk_pin}),
		.s2   (pin_s2),
		.s3   (pin_s3)
	);

	acm_link u_link (
		.link_clk  (sclk_link),
		.srst      (srst),
		.lrclk     (lrclk_pin),
		.bits      (lk_bits),
		.short_low (lk_short),
		.tgl       (lk_tgl)
	);

	always_comb begin
		st_nxt    = st_r;
		ap_valid  = hsel && htrans[1] && hready;
		ap_idx    = (haddr[31:10] == 22'h00_0000) ? haddr[9:2] : 8'hFF;
		ap_rd     = ap_valid && !hwrite;
		rd_err    = ap_rd && (ap_idx == `ACM_IDX_ERR);
		frame_evt = st_r.tg_s2 ^ st_r.tg_d;

		// pins: a change counts once stages two and three agree
		if (pin_s2[0] == pin_s3[0]) st_nxt.mclk_q = pin_s3[0];
		if (pin_s2[1] == pin_s3[1]) st_nxt.lr_q = pin_s3[1];
		if (pin_s2[2] == pin_s3[2]) st_nxt.sck_q = pin_s3[2];
		if (pin_s2[3] == pin_s3[3]) st_nxt.pll_q = pin_s3[3];

		// frame word crossing
		st_nxt.tg_s1 = lk_tgl;
		st_nxt.tg_s2 = st_r.tg_s1;
		st_nxt.tg_d  = st_r.tg_s2;

		// master clock halt watchdog
		if (st_nxt.mclk_q != st_r.mclk_q) begin
			st_nxt.halt_cnt = '0;
			st_nxt.halted   = 1'b0; // RULE1
		end else if (st_r.halt_cnt < `ACM_HALT_CYC) begin
			st_nxt.halt_cnt = st_r.halt_cnt + 12'h001;
		end else begin
			st_nxt.halted = 1'b1; // RULE1
		end

		// both serial clocks held low
		if (st_r.lr_q || st_r.sck_q) begin
			st_nxt.miss_cnt = '0;
			st_nxt.miss     = 1'b0; // RULE3
		end else if (st_r.miss_cnt < `ACM_MISS_CYC) begin
			st_nxt.miss_cnt = st_r.miss_cnt + 12'h001;
		end else begin
			st_nxt.miss = 1'b1; // RULE3
		end

		// master clock edges per frame
		if (st_nxt.mclk_q && !st_r.mclk_q && st_r.mclk_cnt != 12'hFFF) begin
			st_nxt.mclk_cnt = st_r.mclk_cnt + 12'h001;
		end

		// frame capture and sample rate timeout
		if (frame_evt) begin
			st_nxt.bits_prev = st_r.bits_cur;
			st_nxt.bits_cur  = lk_bits;
			st_nxt.low_short = lk_short;
			st_nxt.ratio     = st_nxt.mclk_cnt;
			st_nxt.mclk_cnt  = '0;
			st_nxt.frame_cnt = '0;
			st_nxt.frame_ok  = 1'b1; // RULE8
		end else if (st_r.frame_cnt < `ACM_FRAME_CYC) begin
			st_nxt.frame_cnt = st_r.frame_cnt + 12'h001;
		end else begin
			st_nxt.frame_ok = 1'b0; // RULE8
		end

		// live detector flags
		ratio_ok = acm_ratio_ok(st_r.ratio);
		sr_inv   = !st_r.frame_ok && !st_r.ctl[`ACM_B_IGN]; // RULE9
		minv     = !st_r.frame_ok || st_r.halted || !ratio_ok || st_r.low_short; // RULE5 RULE6
		binv     = !st_r.frame_ok || (st_r.bits_cur != st_r.bits_prev) ||
		           (st_r.bits_cur < `ACM_BCK_MIN) || (st_r.bits_cur > `ACM_BCK_MAX); // RULE7
		auto_err = !st_r.frame_ok || !ratio_ok; // RULE4
		pll_unl  = !(st_r.pll_q && st_r.ctl[`ACM_B_PLLEN]); // RULE2
		any_err  = st_r.halted || minv || binv || !st_r.frame_ok;

		// resync window after errors clear
		st_nxt.err_d  = any_err;
		st_nxt.halt_d = st_r.halted;
		if (any_err) begin
			st_nxt.rsy_cnt = '0;
		end else if (st_r.err_d) begin
			st_nxt.rsy_cnt = `ACM_RESYNC_CYC; // RULE12
		end else if (st_r.rsy_cnt != 12'h000) begin
			st_nxt.rsy_cnt = st_r.rsy_cnt - 12'h001;
		end
		rsy = (st_r.rsy_cnt != 12'h000);

		// sticky flags: a new event wins over a clearing read
		st_nxt.latched_halt_flag = (st_r.halted && !st_r.halt_d) || (st_r.latched_halt_flag && !rd_err); // RULE10
		st_nxt.clock_error_flag = (any_err && !st_r.err_d) || (st_r.clock_error_flag && !rd_err); // RULE11

		// data phase write: only reserved and control bits store
		if (st_r.dp_wr) begin
			case (st_r.dp_idx)
				`ACM_IDX_DET: st_nxt.det_rsv = hwdata[7:0] & `ACM_DET_RSV; // RULE14
				`ACM_IDX_ERR: st_nxt.err_rsv = hwdata[7:0] & `ACM_ERR_RSV; // RULE14
				`ACM_IDX_CTL: st_nxt.ctl = hwdata[7:0];
				default: ;
			endcase
		end

		det_live = '0;
		det_live[`ACM_B_HALT]  = st_r.halted; // RULE1
		det_live[`ACM_B_PLL]   = pll_unl; // RULE2
		det_live[`ACM_B_SMISS] = st_r.miss; // RULE3
		det_live[`ACM_B_AUTO]  = auto_err; // RULE4
		det_live[`ACM_B_MINV]  = minv; // RULE5
		det_live[`ACM_B_BINV]  = binv; // RULE7
		det_live[`ACM_B_SINV]  = sr_inv; // RULE8
		err_live = '0;
		err_live[`ACM_B_LATCHED_HALT_FLAG] = st_r.latched_halt_flag; // RULE10
		err_live[`ACM_B_CLOCK_MISSING_FLAG] = st_r.miss; // RULE13
		err_live[`ACM_B_RESYNC_IN_PROGRESS] = rsy; // RULE12
		err_live[`ACM_B_CLOCK_ERROR_FLAG] = st_r.clock_error_flag; // RULE11

		// address phase: read data from post-write values
		st_nxt.dp_wr  = ap_valid && hwrite;
		st_nxt.dp_idx = ap_idx;
		st_nxt.hready = 1'b1;
		if (ap_rd) begin
			case (ap_idx)
				`ACM_IDX_DET: st_nxt.rdata = st_nxt.det_rsv | det_live; // RULE14
				`ACM_IDX_ERR: st_nxt.rdata = st_nxt.err_rsv | err_live;
				`ACM_IDX_CTL: st_nxt.rdata = st_nxt.ctl;
				default:      st_nxt.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_r         <= '0;
			st_r.det_rsv <= `ACM_RSV_RST;
			st_r.err_rsv <= `ACM_RSV_RST;
			st_r.ctl     <= `ACM_CTL_RST;
			st_r.hready  <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign hreadyout = st_r.hready;
	assign hresp     = 1'b0;
	assign hrdata    = {24'h00_0000, st_r.rdata};

	// checks
	logic rd_det;
	assign rd_det = ap_rd && (ap_idx == `ACM_IDX_DET);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	AST_HALT_CLR: assert property ((st_nxt.mclk_q != st_r.mclk_q) |=> !st_r.halted) // RULE1
		else $error("halt flag stayed set after a master clock edge");
	AST_PLL_OFF: assert property ((rd_det && !st_r.ctl[`ACM_B_PLLEN]) |=> hrdata[`ACM_B_PLL]) // RULE2
		else $error("pll unlocked not reported with pll disabled");
	AST_MISS_CLR: assert property ((st_r.lr_q || st_r.sck_q) |=> !st_r.miss) // RULE3
		else $error("clocks missing set while a serial clock is high");
	AST_AUTO: assert property ((rd_det && !st_r.frame_ok) |=> hrdata[`ACM_B_AUTO]) // RULE4
		else $error("auto setup error not reported without frames");
	AST_SHORT_LOW: assert property ((rd_det && st_r.low_short) |=> hrdata[`ACM_B_MINV]) // RULE6
		else $error("short frame low phase not flagged");
	AST_BCK_RANGE: assert property ((rd_det && st_r.bits_cur > `ACM_BCK_MAX) |=> hrdata[`ACM_B_BINV]) // RULE7
		else $error("bit clock ratio above range not flagged");
	AST_IGNORE: assert property ((rd_det && st_r.ctl[`ACM_B_IGN]) |=> !hrdata[`ACM_B_SINV]) // RULE9
		else $error("sample rate flag set while ignored");
	AST_LATCHED_HALT_FLAG_SET: assert property ($rose(st_r.halted) |=> st_r.latched_halt_flag ##1 (st_r.latched_halt_flag || $past(rd_err))) // RULE10
		else $error("latched halt not captured");
	AST_CLOCK_ERROR_FLAG_CLR: assert property ((rd_err && st_r.err_d && any_err) |=> !st_r.clock_error_flag) // RULE11
		else $error("clock error not cleared by read");
	AST_RESYNC: assert property ((st_r.err_d && !any_err) |=> // RULE12
		rsy ##1 (rsy || $past(any_err)))
		else $error("resync window not started");
	AST_RSV_WR: assert property ((st_r.dp_wr && st_r.dp_idx == `ACM_IDX_DET) |=>
		(st_r.det_rsv == ($past(hwdata[7:0]) & `ACM_DET_RSV))) // RULE14
		else $error("reserved detector bit did not store the write");
	AST_ERR_RSV_WR: assert property ((st_r.dp_wr && st_r.dp_idx == `ACM_IDX_ERR) |=> // RULE14
		(st_r.err_rsv == ($past(hwdata[7:0]) & `ACM_ERR_RSV)))
		else $error("reserved error bits did not store the write");
	AST_HALT_SET: assert property (((st_r.halt_cnt == `ACM_HALT_CYC) && // RULE1
		(st_nxt.mclk_q == st_r.mclk_q)) |=> st_r.halted)
		else $error("halt flag not set after the halt time");
	AST_MISS_SET: assert property ((!st_r.lr_q && !st_r.sck_q && // RULE3
		(st_r.miss_cnt == `ACM_MISS_CYC)) |=> st_r.miss)
		else $error("clocks missing not set after the missing time");

	// flags as read back
	AST_PLL_LOST: assert property ((rd_det && !st_r.pll_q) |=> hrdata[`ACM_B_PLL]) // RULE2
		else $error("pll unlocked not reported while unlocked");
	AST_PLL_OK: assert property ((rd_det && st_r.pll_q && st_r.ctl[`ACM_B_PLLEN]) |=> // RULE2
		!hrdata[`ACM_B_PLL])
		else $error("pll unlocked reported while locked and enabled");
	AST_MINV_RATIO: assert property ((rd_det && !ratio_ok) |=> hrdata[`ACM_B_MINV]) // RULE5
		else $error("undetectable master clock ratio not flagged");
	AST_BCK_UNSTABLE: assert property ((rd_det && // RULE7
		(st_r.bits_cur != st_r.bits_prev)) |=> hrdata[`ACM_B_BINV])
		else $error("changing bit clock ratio not flagged");
	AST_BCK_LOW: assert property ((rd_det && // RULE7
		(st_r.bits_cur < `ACM_BCK_MIN)) |=> hrdata[`ACM_B_BINV])
		else $error("bit clock ratio below range not flagged");
	AST_RATE_LOST: assert property ((rd_det && !st_r.frame_ok && // RULE8
		!st_r.ctl[`ACM_B_IGN]) |=> hrdata[`ACM_B_SINV])
		else $error("missing sample rate not flagged");
	AST_RATE_OK: assert property ((rd_det && st_r.frame_ok) |=> !hrdata[`ACM_B_SINV]) // RULE8
		else $error("sample rate flagged while frames arrive");

	// sticky, resync and mirrored flags
	AST_LATCHED_HALT_FLAG_CLR: assert property ((rd_err && st_r.latched_halt_flag && // RULE10
		!(st_r.halted && !st_r.halt_d)) |=> !st_r.latched_halt_flag)
		else $error("latched halt not cleared by read");
	AST_CLOCK_ERROR_FLAG_SET: assert property ((any_err && !st_r.err_d) |=> st_r.clock_error_flag) // RULE11
		else $error("clock error not latched");
	AST_RESYNC_OFF: assert property (any_err |=> !rsy) // RULE12
		else $error("resync flag high while an error stands");
	AST_MISS_MIRROR: assert property (rd_err |=> // RULE13
		(hrdata[`ACM_B_CLOCK_MISSING_FLAG] == $past(st_r.miss)))
		else $error("clock missing bit differs from the detector");

	COV_HALT: cover property ($rose(st_r.halted));
	COV_MISS: cover property ($rose(st_r.miss));
	COV_GOOD: cover property (rd_det ##1 (hrdata[6:0] == 7'h00));
	COV_CLR:  cover property (rd_err && st_r.clock_error_flag ##1 !st_r.clock_error_flag);
	COV_RSY:  cover property ($rose(rsy));
endmodule

/* File: verif/acm_src_model.sv */
// Purpose: audio serial source driving master, bit and frame clocks
// Assumes: bit clock period 125 ns; frame clock changes on falling bit clock
// Notes:   clocks park low while disabled; master clock runs at twice the bit rate
`timescale 1ns/10ps
module acm_src_model (
	input  wire logic       en,
	input  wire logic       mclk_en,
	input  wire logic [9:0] nbits,
	input  wire logic [9:0] nlow,
	output logic            mclk_pin,
	output logic            lrclk_pin,
	output logic            sclk_link
);
	initial begin
		mclk_pin = 1'b0;
		forever begin
			#31.25;
			mclk_pin = mclk_en ? ~mclk_pin : 1'b0;
		end
	end
	// bit clock stands still outside frames
	initial begin
		sclk_link = 1'b0;
		lrclk_pin = 1'b0;
		#3.7;
		forever begin
			if (!en) begin
				sclk_link = 1'b0;
				lrclk_pin = 1'b0;
				#62.5;
			end else begin
				for (int i = 0; i < int'(nbits); i++) begin
					lrclk_pin = (i < int'(nbits) - int'(nlow));
					#62.5 sclk_link = 1'b1;
					#62.5 sclk_link = 1'b0;
				end
			end
		end
	end
endmodule

/* File: verif/audio_clock_monitor_status_bench.sv */
// Purpose: self-checking bench for the clock detector status registers
// Assumes: one AHB-Lite slave, zero wait states expected but not assumed
// Notes:   frame and clock conditions come from the source model
`include "acm_defines.svh"
`timescale 1ns/10ps
module audio_clock_monitor_status_bench;
	import acm_pkg::*;
	logic       ref_clk = 1'b0;
	logic       srst = 1'b1;
	logic       hsel = 1'b0;
	logic       hwrite = 1'b0;
	logic       pll_lock = 1'b1;
	logic       en = 1'b1;
	logic       mclk_en = 1'b1;
	acm_word_t  haddr = '0;
	acm_word_t  hwdata = '0;
	acm_trans_t htrans = '0;
	logic       hreadyout;
	logic       hresp;
	acm_word_t  hrdata;
	logic       mclk_pin;
	logic       lrclk_pin;
	logic       sclk_link;
	logic [9:0] nbits = 10'h040;
	logic [9:0] nlow = 10'h020;
	logic [7:0] rd;
	logic [7:0] wv;
	int         n_fail = 0;
	int         n_compared = 0;
	int         seed = 39379;
	logic [9:0] tbl [4] = '{10'h01F, 10'h020, 10'h100, 10'h101};

	always #5 ref_clk = ~ref_clk;

	acm_top DUT (.ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.mclk_pin(mclk_pin), .lrclk_pin(lrclk_pin), .sclk_link(sclk_link),
		.pll_lock(pll_lock));
	acm_src_model SRC (.en(en), .mclk_en(mclk_en), .nbits(nbits), .nlow(nlow),
		.mclk_pin(mclk_pin), .lrclk_pin(lrclk_pin), .sclk_link(sclk_link));

	function automatic logic [7:0] rsv(input logic [7:0] m, input logic [7:0] w);
		rsv = m & w;
	endfunction
	function automatic logic exp_binv(input logic [9:0] n);
		exp_binv = (n < `ACM_BCK_MIN) || (n > `ACM_BCK_MAX);
	endfunction
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic xfer(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
		@(posedge ref_clk);
		hsel <= 1'b1;
		haddr <= {22'h00_0000, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h00_0000, wd};
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata[7:0];
	endtask
	task automatic rb(input logic [7:0] idx, input int b, input logic e, input string nm);
		xfer(idx, 1'b0, 8'h00);
		chk(nm, {7'h00, rd[b]}, {7'h00, e});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		#700000;
		n_fail++;
		final_report;
	end

	initial begin
		cyc(40);
		srst <= 1'b0;
		xfer(`ACM_IDX_CTL, 1'b0, 8'h00);
		chk("ctl reset", rd, `ACM_CTL_RST);
		chk("hresp", {7'h00, hresp}, 8'h00);
		xfer(`ACM_IDX_DET, 1'b0, 8'h00);
		chk("det rsv reset", rd & `ACM_DET_RSV, `ACM_RSV_RST);
		xfer(`ACM_IDX_ERR, 1'b0, 8'h00);
		chk("err rsv reset", rd & `ACM_ERR_RSV, `ACM_RSV_RST);
		cyc(3000);
		xfer(`ACM_IDX_DET, 1'b0, 8'h00);
		chk("det live", rd & 8'h7F, 8'h00);
		rb(`ACM_IDX_ERR, `ACM_B_CLOCK_MISSING_FLAG, 1'b0, "clock_missing_flag present");
		rb(`ACM_IDX_ERR, `ACM_B_RESYNC_IN_PROGRESS, 1'b0, "resync idle");
		for (int i = 0; i < 4; i++) begin
			wv = 8'($random(seed));
			xfer(`ACM_IDX_DET, 1'b1, wv);
			xfer(`ACM_IDX_DET, 1'b0, 8'h00);
			chk("det write", rd & 8'hF3, rsv(`ACM_DET_RSV, wv));
			xfer(`ACM_IDX_ERR, 1'b1, wv);
			xfer(`ACM_IDX_ERR, 1'b0, 8'h00);
			chk("err write", rd & 8'hEC, rsv(`ACM_ERR_RSV, wv));
		end
		pll_lock <= 1'b0;
		cyc(10);
		rb(`ACM_IDX_DET, `ACM_B_PLL, 1'b1, "pll lost");
		pll_lock <= 1'b1;
		xfer(`ACM_IDX_CTL, 1'b1, 8'h00);
		cyc(10);
		rb(`ACM_IDX_DET, `ACM_B_PLL, 1'b1, "pll off");
		xfer(`ACM_IDX_CTL, 1'b1, `ACM_CTL_RST);
		cyc(10);
		rb(`ACM_IDX_DET, `ACM_B_PLL, 1'b0, "pll on");
		// master clock halt, latched flags cleared by reading
		xfer(`ACM_IDX_ERR, 1'b0, 8'h00);
		mclk_en <= 1'b0;
		cyc(300);
		rb(`ACM_IDX_DET, `ACM_B_HALT, 1'b1, "halted");
		cyc(2000);
		rb(`ACM_IDX_DET, `ACM_B_MINV, 1'b1, "mclk invalid");
		xfer(`ACM_IDX_ERR, 1'b0, 8'h00);
		chk("latched flags", rd & 8'h11, 8'h11);
		mclk_en <= 1'b1;
		cyc(300);
		rb(`ACM_IDX_DET, `ACM_B_HALT, 1'b0, "mclk back");
		rb(`ACM_IDX_ERR, `ACM_B_LATCHED_HALT_FLAG, 1'b0, "latched_halt_flag cleared");
		// bit clock ratio boundaries
		foreach (tbl[i]) begin
			nbits <= tbl[i];
			nlow <= tbl[i] >> 1;
			cyc(int'(tbl[i]) * 38 + 300);
			rb(`ACM_IDX_DET, `ACM_B_BINV, exp_binv(tbl[i]), "bclk ratio");
		end
		nbits <= 10'h040;
		nlow <= `ACM_LOW_SHORT;
		cyc(3000);
		rb(`ACM_IDX_DET, `ACM_B_MINV, 1'b1, "short low");
		nlow <= 10'h020;
		en <= 1'b0;
		cyc(3000);
		rb(`ACM_IDX_DET, `ACM_B_SMISS, 1'b1, "clocks missing");
		rb(`ACM_IDX_ERR, `ACM_B_CLOCK_MISSING_FLAG, 1'b1, "clock_missing_flag missing");
		cyc(2000);
		xfer(`ACM_IDX_DET, 1'b0, 8'h00);
		chk("no frames", rd & 8'h09, 8'h09);
		xfer(`ACM_IDX_CTL, 1'b1, 8'h03);
		cyc(10);
		rb(`ACM_IDX_DET, `ACM_B_SINV, 1'b0, "rate ignored");
		final_report;
	end
endmodule
